//--- rtl/cbit_port.sv
// Buffer and top module of the DS3 C-bit overhead access port.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "cbit_port_cfg.svh"
module cbit_fifo #(
	parameter int WIDTH = 6,
	parameter int DEPTH = `RX_FIFO_DEPTH
) (
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// Filling side.
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// Draining side.
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
			$error("cbit_fifo needs a power-of-two depth of at least 2");
		end
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, rd_ptr;
	logic [CW-1:0] count;
	logic push, pop;
	assign push = in_valid_in && in_ready_out;
	assign pop = out_valid_out && out_ready_in;
	assign out_valid_out = (count != '0);
	assign out_data_out = mem[rd_ptr];
	always_ff @(posedge sys_clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_out <= 1'b0;
		end else begin
			wr_ptr <= wr_ptr + AW'(push);
			rd_ptr <= rd_ptr + AW'(pop);
			count <= count + CW'(push) - CW'(pop);
			in_ready_out <= (count + CW'(push) - CW'(pop)) < CW'(DEPTH);
		end
	end
endmodule

// Function
// - The receive gapped clock pulses only for receive C-bits and the data changes with its rise.
// - The receive data carries C2 to C6 and C13 to C21 of every frame in order, fourteen bits.
// - A high receive framing pulse comes just before C2 is presented.
// - The receive data-link marker is high over C13 to C15 and only while enabled.
// - The transmit gapped clock pulses only in transmit slots and input data is taken at its rise.
// - Transmit slots are C2, C4 to C6 and C13 to C21, plus C3 when the FEAC select bit is set.
// - A high transmit framing pulse comes just before the C2 slot.
// - The transmit data-link marker is high over C13 to C15 and only while enabled.
// - A low output disable floats every pin except the two data-link markers.
// - The data-link markers float while their enable is low and are driven while it is high.
// - The processor interface runs from the same system clock as the multiplexer.
// - Loss of external clock edges moves the transmit timing to the recovered receive clock.
// - A one in the loop-timing bit makes the recovered receive clock the transmit clock.
module cbit_port
	import cbit_port_pkg::*;
#(
	parameter int FAIL_LIMIT = `CLK_FAIL_LIMIT,
	parameter int FIFO_DEPTH = `RX_FIFO_DEPTH
) (
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// APB slave.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Pins from outside.
	input wire logic ext_tx_clock_in,
	input wire logic recovered_rx_clock_in,
	input wire logic tx_overhead_data_in,
	input wire logic output_disable_n_in,
	input wire logic datalink_marker_enable_in,
	// Receive C-bits from the demultiplexer.
	input wire logic rx_cbit_valid_in,
	input wire cbit_word_t rx_cbit_in,
	output logic rx_cbit_ready_out,
	// Transmit C-bits to the multiplexer.
	output logic tx_cbit_valid_out,
	output cbit_word_t tx_cbit_out,
	// Receive overhead pins.
	output logic rx_overhead_gapped_clock_out,
	output logic rx_overhead_data_out,
	output logic rx_overhead_frame_pulse_out,
	output logic rx_datalink_marker_out,
	// Transmit overhead pins.
	output logic tx_overhead_gapped_clock_out,
	output logic tx_overhead_frame_pulse_out,
	output logic tx_datalink_marker_out,
	// Pin enables and clock state.
	output logic overhead_oe_out,
	output logic datalink_oe_out,
	output logic tx_clock_from_rx_out
);
	localparam int FW = $clog2(FAIL_LIMIT + 1);
	initial begin
		if (FAIL_LIMIT < 2 || FIFO_DEPTH < 2) begin
			$error("cbit_port needs a fail limit and buffer depth of at least 2");
		end
	end
	function automatic logic rx_selected(input logic [4:0] n);
		rx_selected = (n >= `CB_C2 && n <= `CB_C6) || (n >= `CB_C13 && n <= `CB_LAST);
	endfunction
	// Pin inputs: two flops each, then a third for edge finding on the clocks.
	logic [4:0] sync1, sync2;
	logic [1:0] clk_prev;
	logic ext_rise, rx_rise, rx_fall, tx_rise, tx_fall;
	logic datalink_marker_enable, outen, tx_data;
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			sync1 <= 5'h10;
			sync2 <= 5'h10;
			clk_prev <= 2'h0;
		end else begin
			sync1 <= {output_disable_n_in, datalink_marker_enable_in, tx_overhead_data_in,
				recovered_rx_clock_in, ext_tx_clock_in};
			sync2 <= sync1;
			clk_prev <= sync2[1:0];
		end
	end
	assign ext_rise = sync2[0] && !clk_prev[0];
	assign rx_rise = sync2[1] && !clk_prev[1];
	assign rx_fall = !sync2[1] && clk_prev[1];
	assign tx_data = sync2[2];
	assign datalink_marker_enable = sync2[3];
	assign outen = sync2[4];
	// Registers and APB slave; one wait state, so pready comes from a flop.
	logic [7:0] clock_ctrl, feac_ctrl;
	logic loop_timing, feac_select, ext_fail, use_rx, apb_done;
	logic [5:0] idx;
	assign idx = paddr_in[7:2];
	assign loop_timing = clock_ctrl[`LOOP_TIMING_BIT];
	assign feac_select = feac_ctrl[`FEAC_SELECT_BIT];
	assign apb_done = psel_in && penable_in && pready_out;
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0;
		end else if (psel_in && penable_in && !pready_out) begin
			pready_out <= 1'b1;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0;
			case (idx)
				`IDX_CLOCK_CTRL: prdata_out <= {24'h0, clock_ctrl};
				`IDX_FEAC_CTRL: prdata_out <= {24'h0, feac_ctrl};
				`IDX_STATUS: begin
					prdata_out[`STAT_EXT_FAIL_BIT] <= ext_fail;
					prdata_out[`STAT_USE_RX_BIT] <= use_rx;
				end
				default: pslverr_out <= 1'b1;
			endcase
		end else begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			clock_ctrl <= `CLOCK_CTRL_RESET;
			feac_ctrl <= `FEAC_CTRL_RESET;
		end else if (apb_done && pwrite_in) begin
			if (idx == `IDX_CLOCK_CTRL) begin
				clock_ctrl <= pwdata_in[7:0];
			end
			if (idx == `IDX_FEAC_CTRL) begin
				feac_ctrl <= pwdata_in[7:0];
			end
		end
	end
	// External clock watch; an edge clears the count and ends the failure.
	logic [FW-1:0] fail_cnt;
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			fail_cnt <= '0;
			ext_fail <= 1'b0;
		end else if (ext_rise) begin
			fail_cnt <= '0;
			ext_fail <= 1'b0;
		end else if (rx_rise) begin
			if (fail_cnt == FW'(FAIL_LIMIT)) begin
				ext_fail <= 1'b1;
			end else begin
				fail_cnt <= fail_cnt + FW'(1);
			end
		end
	end
	// Register logic runs on the system clock; the selected source is reported to software.
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			use_rx <= 1'b0;
		end else begin
			use_rx <= loop_timing || ext_fail;
		end
	end
	assign tx_rise = use_rx ? rx_rise : ext_rise;
	assign tx_fall = use_rx ? rx_fall : (!sync2[0] && clk_prev[0]);
	// Receive path: buffer selected C-bits, shift them out on recovered clock edges.
	cbit_word_t fifo_head;
	logic fifo_valid, fifo_in_valid, rx_pop;
	rx_state_t rx_state;
	logic [4:0] rx_cur;
	// Unselected C-bits are accepted and dropped, but only while the buffer has room, as the ready output is shared.
	assign fifo_in_valid = rx_cbit_valid_in && rx_selected(rx_cbit_in.index);
	cbit_fifo #(.WIDTH($bits(cbit_word_t)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in),
		.in_valid_in(fifo_in_valid),
		.in_data_in(rx_cbit_in),
		.in_ready_out(rx_cbit_ready_out),
		.out_valid_out(fifo_valid),
		.out_data_out(fifo_head),
		.out_ready_in(rx_pop)
	);
	assign rx_pop = rx_rise && fifo_valid &&
		(rx_state == RX_FRAME || fifo_head.index != `CB_C2);
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			rx_state <= RX_SHIFT;
			rx_overhead_frame_pulse_out <= 1'b0;
		end else if (rx_rise) begin
			case (rx_state)
				RX_SHIFT: begin
					if (fifo_valid && fifo_head.index == `CB_C2) begin
						rx_state <= RX_FRAME;
						rx_overhead_frame_pulse_out <= 1'b1;
					end
				end
				RX_FRAME: begin
					rx_state <= RX_SHIFT;
					rx_overhead_frame_pulse_out <= 1'b0;
				end
				default: begin
					rx_state <= RX_SHIFT;
					rx_overhead_frame_pulse_out <= 1'b0;
				end
			endcase
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			rx_overhead_gapped_clock_out <= 1'b0;
			rx_overhead_data_out <= 1'b1;
			rx_cur <= 5'h0;
		end else if (rx_pop) begin
			rx_overhead_gapped_clock_out <= 1'b1;
			rx_overhead_data_out <= fifo_head.value;
			rx_cur <= fifo_head.index;
		end else if (rx_fall) begin
			rx_overhead_gapped_clock_out <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			rx_datalink_marker_out <= 1'b0;
		end else begin
			rx_datalink_marker_out <= datalink_marker_enable && rx_cur >= `CB_C13 && rx_cur <= `CB_C15;
		end
	end
	// Transmit path: a slot count over C1 to C21 paced by the selected transmit clock.
	logic [4:0] tx_slot, next_slot;
	logic tx_take;
	assign next_slot = (tx_slot == `CB_LAST) ? `CB_FRAME_SLOT : tx_slot + 5'h01;
	assign tx_take = rx_selected(next_slot) || (next_slot == `CB_C3);
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			tx_slot <= `CB_LAST;
			tx_overhead_gapped_clock_out <= 1'b0;
			tx_overhead_frame_pulse_out <= 1'b0;
		end else if (tx_rise) begin
			tx_slot <= next_slot;
			tx_overhead_frame_pulse_out <= (next_slot == `CB_FRAME_SLOT);
			tx_overhead_gapped_clock_out <= tx_take &&
				(next_slot != `CB_C3 || feac_select);
		end else if (tx_fall) begin
			tx_overhead_gapped_clock_out <= 1'b0;
		end
	end
	// The data pin is taken at the cycle the gapped clock rises, two flops late by design.
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			tx_cbit_valid_out <= 1'b0;
			tx_cbit_out <= '0;
		end else begin
			tx_cbit_valid_out <= tx_rise && tx_take && (next_slot != `CB_C3 || feac_select);
			if (tx_rise) begin
				tx_cbit_out <= '{index: next_slot, value: tx_data};
			end
		end
	end
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			tx_datalink_marker_out <= 1'b0;
		end else begin
			tx_datalink_marker_out <= datalink_marker_enable && tx_slot >= `CB_C13 && tx_slot <= `CB_C15;
		end
	end
	// Pin enables; the markers ignore the output disable.
	always_ff @(posedge sys_clk_in) begin
		if (!rstn_in) begin
			overhead_oe_out <= 1'b0;
			datalink_oe_out <= 1'b0;
			tx_clock_from_rx_out <= 1'b0;
		end else begin
			overhead_oe_out <= outen;
			datalink_oe_out <= datalink_marker_enable;
			tx_clock_from_rx_out <= use_rx;
		end
	end
	a_rx_clock_data: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(rx_overhead_gapped_clock_out) |-> $past(rx_pop))
		else $error("receive gapped clock rose without a new bit");
	a_rx_bit_select: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(rx_overhead_gapped_clock_out) |-> rx_selected(rx_cur))
		else $error("receive bit outside the C-bit set");
	a_rx_frame_c2: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$fell(rx_overhead_frame_pulse_out) |-> rx_cur == `CB_C2)
		else $error("receive framing pulse not followed by C2");
	a_rx_marker_span: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		rx_datalink_marker_out |-> $past(datalink_marker_enable) && $past(rx_cur) >= `CB_C13
			&& $past(rx_cur) <= `CB_C15)
		else $error("receive marker outside C13 to C15");
	a_tx_c3_gate: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(tx_overhead_gapped_clock_out) && tx_slot == `CB_C3 |-> $past(feac_select))
		else $error("C3 gated in without the FEAC select bit");
	a_tx_take_data: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(tx_overhead_gapped_clock_out) |-> tx_cbit_valid_out && tx_cbit_out.index == tx_slot)
		else $error("transmit bit not taken at the gapped clock rise");
	a_tx_frame_slot: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(tx_overhead_frame_pulse_out) |-> tx_slot == `CB_FRAME_SLOT
			&& !tx_overhead_gapped_clock_out)
		else $error("transmit framing pulse outside the slot before C2");
	a_tx_marker_span: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		tx_datalink_marker_out |-> $past(datalink_marker_enable) && $past(tx_slot) >= `CB_C13
			&& $past(tx_slot) <= `CB_C15)
		else $error("transmit marker outside C13 to C15");
	a_oe_follow: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		rstn_in |=> overhead_oe_out == $past(outen) && datalink_oe_out == $past(datalink_marker_enable))
		else $error("pin enable does not follow its control pin");
	a_fail_switch: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		rx_rise && !ext_rise && fail_cnt == FW'(FAIL_LIMIT) |=> ##1 use_rx)
		else $error("no switch to the receive clock after clock loss");
	a_loop_timing: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		loop_timing |=> use_rx)
		else $error("loop timing did not select the receive clock");
endmodule

//--- rtl/cbit_port_cfg.svh
// Register indices, field positions, reset values and counts of the C-bit access port.
`ifndef CBIT_PORT_CFG_SVH
`define CBIT_PORT_CFG_SVH

// Register indices; the byte address is four times the index.
`define IDX_CLOCK_CTRL 6'h02
`define IDX_FEAC_CTRL 6'h19
`define IDX_STATUS 6'h20

// Field positions.
`define LOOP_TIMING_BIT 3
`define FEAC_SELECT_BIT 7
`define STAT_EXT_FAIL_BIT 0
`define STAT_USE_RX_BIT 1

// Reset values.
`define CLOCK_CTRL_RESET 8'h00
`define FEAC_CTRL_RESET 8'h00

// Receive clock edges without an external clock edge before failure is declared.
`define CLK_FAIL_LIMIT 16

// Buffer depth between the demultiplexer and the receive port.
`define RX_FIFO_DEPTH 32

// C-bit numbers of the frame.
`define CB_LAST 5'h15
`define CB_FRAME_SLOT 5'h01
`define CB_C2 5'h02
`define CB_C3 5'h03
`define CB_C6 5'h06
`define CB_C13 5'h0D
`define CB_C15 5'h0F

`endif

//--- rtl/cbit_port_pkg.sv
// Types shared by the C-bit access port.
package cbit_port_pkg;
	typedef struct packed {
		logic [4:0] index;
		logic value;
	} cbit_word_t;

	typedef enum logic [0:0] {
		RX_SHIFT = 1'b0,
		RX_FRAME = 1'b1
	} rx_state_t;
endpackage

//--- verif/cbit_far_end.sv
// Model of the outside C-bit logic that faces the overhead port.
`timescale 1ns/1ps
module cbit_far_end (
	// Receive overhead pins.
	input wire logic rx_gclk_in,
	input wire logic rx_data_in,
	input wire logic rx_frame_in,
	// Transmit data pin.
	output logic tx_data_out,
	// Receive bits captured since the last framing pulse.
	output logic [13:0] rx_bits_out,
	output logic [4:0] rx_count_out
);
	// No transmit slot carries traffic here, so each one is sent as a one.
	assign tx_data_out = 1'b1;

	// Bits are taken on the falling clock edge, half a bit after they change.
	always @(posedge rx_frame_in or negedge rx_gclk_in) begin
		if (rx_frame_in) begin
			rx_count_out <= 5'h00;
		end else begin
			rx_bits_out <= {rx_bits_out[12:0], rx_data_in};
			rx_count_out <= rx_count_out + 5'h01;
		end
	end
endmodule

//--- verif/tb_cbit_port.sv
// Self-checking testbench of the C-bit access port.
`timescale 1ns/1ps
`include "cbit_port_cfg.svh"
module tb_cbit_port
	import cbit_port_pkg::*;
;
	localparam int LIMIT = 4;
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h00000000;
	logic ext_tx_clock_in = 1'b0;
	logic recovered_rx_clock_in = 1'b0;
	logic output_disable_n_in = 1'b1;
	logic datalink_marker_enable_in = 1'b1;
	logic rx_cbit_valid_in = 1'b0;
	cbit_word_t rx_cbit_in = 6'h00;
	logic [31:0] prdata_out;
	logic pready_out, pslverr_out, rx_cbit_ready_out, tx_cbit_valid_out, tx_data;
	cbit_word_t tx_cbit_out;
	logic rx_gclk, rx_data, rx_frame, rx_mark, tx_gclk, tx_frame, tx_mark;
	logic overhead_oe_out, datalink_oe_out, tx_clock_from_rx_out;
	logic [13:0] rx_bits;
	logic [4:0] rx_count;
	logic ext_run = 1'b1;
	logic tx_fp_d = 1'b0, tx_gc_d = 1'b0, rx_fp_d = 1'b0, rx_gc_d = 1'b0;
	int tx_cnt = 0, tx_last = 0, txm_cnt = 0, txm_last = 0, rxm_cnt = 0;
	int miscompares = 0;
	int cmp_count = 0;

	cbit_port #(.FAIL_LIMIT(LIMIT)) dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.ext_tx_clock_in(ext_tx_clock_in), .recovered_rx_clock_in(recovered_rx_clock_in),
		.tx_overhead_data_in(tx_data), .output_disable_n_in(output_disable_n_in),
		.datalink_marker_enable_in(datalink_marker_enable_in),
		.rx_cbit_valid_in(rx_cbit_valid_in), .rx_cbit_in(rx_cbit_in),
		.rx_cbit_ready_out(rx_cbit_ready_out), .tx_cbit_valid_out(tx_cbit_valid_out),
		.tx_cbit_out(tx_cbit_out), .rx_overhead_gapped_clock_out(rx_gclk),
		.rx_overhead_data_out(rx_data), .rx_overhead_frame_pulse_out(rx_frame),
		.rx_datalink_marker_out(rx_mark), .tx_overhead_gapped_clock_out(tx_gclk),
		.tx_overhead_frame_pulse_out(tx_frame), .tx_datalink_marker_out(tx_mark),
		.overhead_oe_out(overhead_oe_out), .datalink_oe_out(datalink_oe_out),
		.tx_clock_from_rx_out(tx_clock_from_rx_out));

	cbit_far_end far_end (.rx_gclk_in(rx_gclk), .rx_data_in(rx_data), .rx_frame_in(rx_frame),
		.tx_data_out(tx_data), .rx_bits_out(rx_bits), .rx_count_out(rx_count));

	always #50 sys_clk_in = ~sys_clk_in;
	always #400 recovered_rx_clock_in = ~recovered_rx_clock_in;
	// The external clock is slowed far below line rate so the system clock can sample it;
	// its toggles never meet a rising system clock edge and the duty cycle stays at half.
	always begin
		#360;
		if (ext_run) begin
			ext_tx_clock_in = ~ext_tx_clock_in;
		end
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Counts gated bits and marker-qualified clock falls between framing pulses.
	always @(posedge sys_clk_in) begin
		tx_fp_d <= tx_frame;
		tx_gc_d <= tx_gclk;
		rx_fp_d <= rx_frame;
		rx_gc_d <= rx_gclk;
		if (tx_frame && !tx_fp_d) begin
			tx_last <= tx_cnt;
			tx_cnt <= 0;
			txm_last <= txm_cnt;
			txm_cnt <= 0;
		end else begin
			if (tx_cbit_valid_out === 1'b1) begin
				tx_cnt <= tx_cnt + 1;
				check("tx bit value", 32'(tx_cbit_out.value), 32'h1);
			end
			if (tx_gc_d && !tx_gclk && tx_mark) begin
				txm_cnt <= txm_cnt + 1;
			end
		end
		if (rx_frame && !rx_fp_d) begin
			rxm_cnt <= 0;
		end else if (rx_gc_d && !rx_gclk && rx_mark) begin
			rxm_cnt <= rxm_cnt + 1;
		end
	end

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= addr;
		pwdata_in <= wd;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		@(posedge sys_clk_in);
		while (pready_out !== 1'b1 && n < 20) begin
			@(posedge sys_clk_in);
			n++;
		end
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge sys_clk_in);
		if (n == 20) begin
			miscompares++;
		end
	endtask

	task automatic test_regs();
		logic [31:0] rd;
		logic err;
		apb(1'b0, {`IDX_CLOCK_CTRL, 2'b00}, 32'h0, rd, err);
		check("clock ctrl reset", rd, 32'(`CLOCK_CTRL_RESET));
		apb(1'b0, {`IDX_FEAC_CTRL, 2'b00}, 32'h0, rd, err);
		check("feac ctrl reset", rd, 32'(`FEAC_CTRL_RESET));
		apb(1'b1, 8'h10, 32'hFF, rd, err);
		check("unmapped write err", 32'(err), 32'h1);
		apb(1'b0, 8'h10, 32'h0, rd, err);
		check("unmapped read data", rd, 32'h0);
	endtask

	task automatic test_rx();
		logic [13:0] exp;
		int n;
		exp = 14'h0000;
		for (int i = 1; i <= 21; i++) begin
			if ((i >= 2 && i <= 6) || i >= 13) begin
				exp = {exp[12:0], ^i[4:0]};
			end
			rx_cbit_valid_in <= 1'b1;
			rx_cbit_in <= {i[4:0], ^i[4:0]};
			@(posedge sys_clk_in);
			n = 0;
			while (rx_cbit_ready_out !== 1'b1 && n < 50) begin
				@(posedge sys_clk_in);
				n++;
			end
		end
		rx_cbit_valid_in <= 1'b0;
		repeat (250) @(posedge sys_clk_in);
		check("rx bit count", 32'(rx_count), 32'd14);
		check("rx bits", 32'(rx_bits), 32'(exp));
		check("rx marker span", 32'(rxm_cnt), 32'd3);
	endtask

	task automatic test_tx();
		logic [31:0] rd;
		logic err;
		repeat (320) @(posedge sys_clk_in);
		check("tx slots plain", 32'(tx_last), 32'd13);
		check("tx marker span", 32'(txm_last), 32'd3);
		apb(1'b1, {`IDX_FEAC_CTRL, 2'b00}, 32'h80, rd, err);
		repeat (320) @(posedge sys_clk_in);
		check("tx slots feac", 32'(tx_last), 32'd14);
		apb(1'b1, {`IDX_FEAC_CTRL, 2'b00}, 32'h0, rd, err);
	endtask

	task automatic test_clock();
		logic [31:0] rd;
		logic err;
		apb(1'b1, {`IDX_CLOCK_CTRL, 2'b00}, 32'h8, rd, err);
		apb(1'b0, {`IDX_STATUS, 2'b00}, 32'h0, rd, err);
		check("loop timing status", rd, 32'h2);
		check("loop timing pin", 32'(tx_clock_from_rx_out), 32'h1);
		apb(1'b1, {`IDX_CLOCK_CTRL, 2'b00}, 32'h0, rd, err);
		ext_run <= 1'b0;
		// The limit is counted in 800 ns receive periods, eight system clocks each.
		repeat ((LIMIT + 3) * 8) @(posedge sys_clk_in);
		apb(1'b0, {`IDX_STATUS, 2'b00}, 32'h0, rd, err);
		check("clock failed status", rd, 32'h3);
		ext_run <= 1'b1;
		repeat (30) @(posedge sys_clk_in);
		apb(1'b0, {`IDX_STATUS, 2'b00}, 32'h0, rd, err);
		check("clock restored status", rd, 32'h0);
	endtask

	task automatic test_pins();
		output_disable_n_in <= 1'b0;
		repeat (5) @(posedge sys_clk_in);
		check("overhead oe off", 32'(overhead_oe_out), 32'h0);
		check("marker oe kept", 32'(datalink_oe_out), 32'h1);
		datalink_marker_enable_in <= 1'b0;
		repeat (5) @(posedge sys_clk_in);
		check("marker oe off", 32'(datalink_oe_out), 32'h0);
		output_disable_n_in <= 1'b1;
		datalink_marker_enable_in <= 1'b1;
		repeat (5) @(posedge sys_clk_in);
		check("overhead oe on", 32'(overhead_oe_out), 32'h1);
	endtask

	initial begin
		repeat (4) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		@(posedge sys_clk_in);
		test_regs();
		test_rx();
		test_tx();
		test_clock();
		test_pins();
		end_of_test();
	end

	initial begin
		repeat (6000) @(posedge sys_clk_in);
		miscompares++;
		end_of_test();
	end
endmodule
